// ===== idcw_host.sv
`timescale 1ns/10ps
`include "idcw_regs.svh"
module idcw_host
  import idcw_pkg::*;
(
  // clock
  input  wire logic          sys_clk,
  // write side
  output idcw_addr_type      aw,
  input  wire logic          awready,
  output idcw_wdat_type      w,
  input  wire logic          wready,
  input  wire logic [1:0]    bresp,
  input  wire logic          bvalid,
  output logic               bready,
  // read side
  output idcw_addr_type      ar,
  input  wire logic          arready,
  input  wire idcw_rdat_type r,
  input  wire logic          rvalid,
  output logic               rready
);
  initial begin
    aw = '0;
    w = '0;
    ar = '0;
    bready = 1'b0;
    rready = 1'b0;
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic ha, hw, hb;
    @(posedge sys_clk);
    aw <= '{a, 1'b1};
    w <= '{d, 4'hf, 1'b1};
    bready <= 1'b1;
    do begin
      @(negedge sys_clk);
      ha = aw.valid && awready;
      hw = w.valid && wready;
      hb = bvalid;
      resp = bresp;
      @(posedge sys_clk);
      if (ha) aw <= '{~a, 1'b0};
      if (hw) w <= '{~d, 4'h0, 1'b0};
    end while (!hb);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ha, hr;
    @(posedge sys_clk);
    ar <= '{a, 1'b1};
    rready <= 1'b1;
    do begin
      @(negedge sys_clk);
      ha = ar.valid && arready;
      hr = rvalid;
      d = r.data;
      resp = r.resp;
      @(posedge sys_clk);
      if (ha) ar <= '{~a, 1'b0};
    end while (!hr);
    rready <= 1'b0;
  endtask : rd
  task automatic id_word(input logic [7:0] n, output logic [31:0] d);
    logic [1:0] resp;
    wr(`IDCW_REG_WSEL, {24'h0, n}, resp);
    repeat (2) @(posedge sys_clk);
    rd(`IDCW_REG_WDATA, d, resp);
  endtask : id_word
  // whether the host may trust a word, given word 53
  function automatic logic usable(input logic [7:0] n, input logic [15:0] w53);
    if (n >= 8'd54 && n <= 8'd58) return w53[0];
    if (n >= 8'd64 && n <= 8'd70) return w53[1];
    return 1'b1;
  endfunction : usable
endmodule : idcw_host

// ===== idcw_pkg.sv
package idcw_pkg;
  typedef struct packed {
    logic [11:0] addr;
    logic        valid;
  } idcw_addr_type;

  typedef struct packed {
    logic [31:0] data;
    logic [3:0]  strb;
    logic        valid;
  } idcw_wdat_type;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  resp;
  } idcw_rdat_type;

  typedef enum logic [1:0] {
    IDCW_W_IDLE = 2'b01,
    IDCW_W_RESP = 2'b10
  } idcw_wstate_type;
endpackage : idcw_pkg

// ===== idcw_properties.sv
`timescale 1ns/10ps
module idcw_properties (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        resetn,
  // write channels
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // read channels
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs  = s_axi_wvalid && s_axi_wready;
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire ar_ok = (s_axi_araddr < 12'h020) && (s_axi_araddr[1:0] == 2'b00);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  arready_gate_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  bvalid_time_a: assert property (aw_hs && w_hs |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response timing wrong");
  rvalid_time_a: assert property (ar_hs |=> s_axi_rvalid)
    else $error("read data late");
  rd_unmapped_a: assert property (ar_hs && !ar_ok |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
    else $error("unmapped read answer wrong");
  rd_mapped_a: assert property (ar_hs && ar_ok |=> s_axi_rresp == 2'b00)
    else $error("mapped read refused");
  wr_unmapped_a: assert property (aw_hs && w_hs && s_axi_awaddr >= 12'h020 |=> ##1 s_axi_bresp == 2'b10)
    else $error("unmapped write answer wrong");
  bvalid_end_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write response not retired");
  wr_c: cover property (aw_hs && w_hs);
  rd_c: cover property (ar_hs && ar_ok);
  bad_c: cover property (ar_hs && !ar_ok);
endmodule : idcw_properties

bind idcw_words idcw_properties u_props (.sys_clk(sys_clk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ===== idcw_regs.svh
`ifndef IDCW_REGS_SVH
`define IDCW_REGS_SVH

// word 2 spin-up / completeness codes
`define IDCW_W2_SPIN_INC   16'h37c8
`define IDCW_W2_SPIN_CMP   16'h738c
`define IDCW_W2_NOSPIN_INC 16'h8c73
`define IDCW_W2_NOSPIN_CMP 16'hc837
`define IDCW_SPACE         8'h20

// identify word indices
`define IDCW_WORD_CFG0   8'h00
`define IDCW_WORD_SPEC   8'h02
`define IDCW_WORD_HEADS  8'h03
`define IDCW_WORD_SECT   8'h06
`define IDCW_SER_FIRST   8'h0a
`define IDCW_SER_LAST    8'h13
`define IDCW_FW_FIRST    8'h17
`define IDCW_FW_LAST     8'h1a
`define IDCW_MOD_FIRST   8'h1b
`define IDCW_MOD_LAST    8'h2e
`define IDCW_WORD_MULT   8'h2f
`define IDCW_WORD_CAP0   8'h31
`define IDCW_WORD_CAP1   8'h32
`define IDCW_WORD_VALID  8'h35
`define IDCW_WORD_CCYL   8'h36
`define IDCW_WORD_CHEAD  8'h37
`define IDCW_WORD_CSECT  8'h38
`define IDCW_WORD_CAPLO  8'h39
`define IDCW_WORD_CAPHI  8'h3a

// axi register byte offsets
`define IDCW_REG_CTRL     12'h000
`define IDCW_REG_GEOM     12'h004
`define IDCW_REG_CURGEOM  12'h008
`define IDCW_REG_CURCAP   12'h00c
`define IDCW_REG_TEXTSEL  12'h010
`define IDCW_REG_TEXTDATA 12'h014
`define IDCW_REG_WSEL     12'h018
`define IDCW_REG_WDATA    12'h01c

// ctrl field positions
`define IDCW_CTRL_SPIN    0
`define IDCW_CTRL_INCOMP  1
`define IDCW_CTRL_STDTMR  2
`define IDCW_CTRL_IORDY   3
`define IDCW_CTRL_IODIS   4
`define IDCW_CTRL_LBA     5
`define IDCW_CTRL_DMA     6
`define IDCW_CTRL_MINTMR  7
`define IDCW_CTRL_GVALID  8
`define IDCW_CTRL_MDMA1   9
`define IDCW_CTRL_UDMA    10
`define IDCW_CTRL_W88OK   11
`define IDCW_CTRL_MULT    16
`define IDCW_CTRL_RESET   32'h0000_0148

`define IDCW_RESP_OKAY   2'b00
`define IDCW_RESP_SLVERR 2'b10

`endif

// ===== idcw_words.sv
`timescale 1ns/10ps
`include "idcw_regs.svh"

// Contract
// R1: word 2 is 37c8 or 738c when spin-up subcommand needed, by completeness.
// R2: word 2 is 8c73 or c837 when no spin-up needed, by completeness.
// R3: words 10-19 hold 20-byte serial text, space padded.
// R4: words 23-26 hold 8-byte firmware revision, space padded.
// R5: words 27-46 hold 40-byte model number, space padded.
// R6: word 47 bits 7-0 give max sectors per multiple block.
// R7: word 49 bits 15, 14, 12 carry nothing here; driven zero.
// R8: word 49 bit 13 one means standard standby timer values.
// R9: word 49 bit 11 set when PIO mode 3 or higher supported.
// R10: word 49 bit 10 reports IORDY can be disabled and re-enabled.
// R11: word 49 bit 8 DMA, bit 9 LBA, bits 7-0 zero.
// R12: word 50 bit 15 zero and bit 14 one; bits 13-2 zero.
// R13: word 50 bit 0 reports a device-specific minimum standby timer.
// R14: word 53 bit 0 qualifies words 54-58.
// R15: word 53 bit 1 set with PIO mode 3+ or multiword DMA 1+.
// R16: word 53 bit 2 set when Ultra DMA supported and word 88 valid.
// R17: words 54-56 give current cylinders, heads, sectors per track.
// R18: words 58:57 give current capacity in sectors.
// R19: word 3 gives default heads, word 6 default sectors per track.
// R20: word 0 bit 2 flags incomplete data, agreeing with word 2.
// R21: each text word holds earlier character high, next character low.
// R22: retired, obsolete, reserved words in range read as zero.
module idcw_words
  import idcw_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // axi4-lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // text store: 20 serial, 8 firmware, 40 model bytes
  logic [7:0]      text_q [0:67];
  logic [31:0]     ctrl_q;
  logic [31:0]     geom_q;
  logic [31:0]     curgeom_q;
  logic [31:0]     curcap_q;
  logic [6:0]      tsel_q;
  logic [7:0]      wsel_q;
  logic [15:0]     wdata_q;
  idcw_addr_type   aw_q;
  idcw_wdat_type   w_q;
  idcw_wstate_type wst_q;
  idcw_rdat_type   rd_q;
  logic            rvalid_q;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // two characters of the text store starting at byte index
  function automatic logic [15:0] text_pair(input logic [6:0] idx);
    return {text_q[idx], text_q[7'(idx + 7'd1)]};
  endfunction : text_pair

  function automatic logic [15:0] identify_word(input logic [7:0] w);
    logic [15:0] res;
    res = 16'h0000;
    if (w == `IDCW_WORD_CFG0) begin
      res[2] = ctrl_q[`IDCW_CTRL_INCOMP];  // see R20
    end else if (w == `IDCW_WORD_SPEC) begin
      if (ctrl_q[`IDCW_CTRL_SPIN]) begin
        res = ctrl_q[`IDCW_CTRL_INCOMP] ? `IDCW_W2_SPIN_INC : `IDCW_W2_SPIN_CMP;  // see R1
      end else begin
        res = ctrl_q[`IDCW_CTRL_INCOMP] ? `IDCW_W2_NOSPIN_INC : `IDCW_W2_NOSPIN_CMP;  // see R2
      end
    end else if (w == `IDCW_WORD_HEADS) begin
      res = geom_q[15:0];  // see R19
    end else if (w == `IDCW_WORD_SECT) begin
      res = geom_q[31:16];  // see R19
    end else if (w >= `IDCW_SER_FIRST && w <= `IDCW_SER_LAST) begin
      res = text_pair(7'((w - `IDCW_SER_FIRST) * 2));  // see R3 see R21
    end else if (w >= `IDCW_FW_FIRST && w <= `IDCW_FW_LAST) begin
      res = text_pair(7'((w - `IDCW_FW_FIRST) * 2 + 20));  // see R4 see R21
    end else if (w >= `IDCW_MOD_FIRST && w <= `IDCW_MOD_LAST) begin
      res = text_pair(7'((w - `IDCW_MOD_FIRST) * 2 + 28));  // see R5 see R21
    end else if (w == `IDCW_WORD_MULT) begin
      res[7:0] = ctrl_q[`IDCW_CTRL_MULT +: 8];  // see R6
    end else if (w == `IDCW_WORD_CAP0) begin
      // bits 15, 14, 12 and 7-0 stay zero; see R7 see R11
      res[13] = ctrl_q[`IDCW_CTRL_STDTMR];  // see R8
      res[11] = ctrl_q[`IDCW_CTRL_IORDY];   // see R9
      res[10] = ctrl_q[`IDCW_CTRL_IODIS];   // see R10
      res[9]  = ctrl_q[`IDCW_CTRL_LBA];     // see R11
      res[8]  = ctrl_q[`IDCW_CTRL_DMA];     // see R11
    end else if (w == `IDCW_WORD_CAP1) begin
      res[15] = 1'b0;  // see R12
      res[14] = 1'b1;  // see R12
      res[0]  = ctrl_q[`IDCW_CTRL_MINTMR];  // see R13
    end else if (w == `IDCW_WORD_VALID) begin
      res[0] = ctrl_q[`IDCW_CTRL_GVALID];  // see R14
      res[1] = ctrl_q[`IDCW_CTRL_IORDY] | ctrl_q[`IDCW_CTRL_MDMA1];  // see R15
      res[2] = ctrl_q[`IDCW_CTRL_UDMA] & ctrl_q[`IDCW_CTRL_W88OK];  // see R16
    end else if (w == `IDCW_WORD_CCYL) begin
      res = curgeom_q[15:0];  // see R17
    end else if (w == `IDCW_WORD_CHEAD) begin
      res = {8'h00, curgeom_q[23:16]};  // see R17
    end else if (w == `IDCW_WORD_CSECT) begin
      res = {8'h00, curgeom_q[31:24]};  // see R17
    end else if (w == `IDCW_WORD_CAPLO) begin
      res = curcap_q[15:0];  // see R18
    end else if (w == `IDCW_WORD_CAPHI) begin
      res = curcap_q[31:16];  // see R18
    end
    return res;  // others zero, see R22
  endfunction : identify_word

  // write channel
  wire logic        aw_take  = s_axi_awvalid & s_axi_awready;
  wire logic        w_take   = s_axi_wvalid & s_axi_wready;
  wire logic        do_write = (wst_q == IDCW_W_IDLE) & aw_q.valid & w_q.valid;
  wire logic [11:0] wa       = aw_q.addr;
  wire logic        wa_ok    = (wa[11:5] == 7'h00) & (wa[1:0] == 2'b00);
  wire logic        wr_ctrl  = do_write & (wa == `IDCW_REG_CTRL);
  wire logic        wr_geom  = do_write & (wa == `IDCW_REG_GEOM);
  wire logic        wr_cgeo  = do_write & (wa == `IDCW_REG_CURGEOM);
  wire logic        wr_ccap  = do_write & (wa == `IDCW_REG_CURCAP);
  wire logic        wr_tsel  = do_write & (wa == `IDCW_REG_TEXTSEL);
  wire logic        wr_text  = do_write & (wa == `IDCW_REG_TEXTDATA);
  wire logic        wr_wsel  = do_write & (wa == `IDCW_REG_WSEL);
  wire logic [31:0] tsel_new = merge({25'h0, tsel_q}, w_q.data, w_q.strb);
  wire logic [31:0] wsel_new = merge({24'h0, wsel_q}, w_q.data, w_q.strb);
  wire logic        tsel_ok  = tsel_q < 7'd68;

  assign s_axi_awready = ~aw_q.valid & (wst_q == IDCW_W_IDLE);
  assign s_axi_wready  = ~w_q.valid & (wst_q == IDCW_W_IDLE);
  assign s_axi_bvalid  = (wst_q == IDCW_W_RESP);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      aw_q          <= '0;
      w_q           <= '0;
      wst_q         <= IDCW_W_IDLE;
      s_axi_bresp   <= `IDCW_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_q <= '{addr: s_axi_awaddr, valid: 1'b1};
      end
      if (w_take) begin
        w_q <= '{data: s_axi_wdata, strb: s_axi_wstrb, valid: 1'b1};
      end
      case (wst_q)
        IDCW_W_IDLE: begin
          if (do_write) begin
            aw_q.valid  <= 1'b0;
            w_q.valid   <= 1'b0;
            s_axi_bresp <= wa_ok ? `IDCW_RESP_OKAY : `IDCW_RESP_SLVERR;
            wst_q       <= IDCW_W_RESP;
          end
        end
        IDCW_W_RESP: begin
          if (s_axi_bready) begin
            wst_q <= IDCW_W_IDLE;
          end
        end
        default: wst_q <= IDCW_W_IDLE;
      endcase
    end
  end

  // configuration registers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctrl_q    <= `IDCW_CTRL_RESET;
      geom_q    <= 32'h0000_0000;
      curgeom_q <= 32'h0000_0000;
      curcap_q  <= 32'h0000_0000;
      tsel_q    <= 7'h00;
      wsel_q    <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= merge(ctrl_q, w_q.data, w_q.strb);
      end
      if (wr_geom) begin
        geom_q <= merge(geom_q, w_q.data, w_q.strb);
      end
      if (wr_cgeo) begin
        curgeom_q <= merge(curgeom_q, w_q.data, w_q.strb);
      end
      if (wr_ccap) begin
        curcap_q <= merge(curcap_q, w_q.data, w_q.strb);
      end
      if (wr_tsel) begin
        tsel_q <= tsel_new[6:0];
      end else if (wr_text & w_q.strb[0] & tsel_ok) begin
        tsel_q <= 7'(tsel_q + 7'd1);
      end
      if (wr_wsel) begin
        wsel_q <= wsel_new[7:0];
      end
    end
  end

  // text bytes reset to spaces; see R3 see R4 see R5
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 68; i++) begin
      if (!resetn) begin
        text_q[i] <= `IDCW_SPACE;
      end else if (wr_text & w_q.strb[0] & tsel_ok & (tsel_q == 7'(i))) begin
        text_q[i] <= w_q.data[7:0];
      end
    end
  end

  // selected identify word, registered
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wdata_q <= 16'h0000;
    end else begin
      wdata_q <= identify_word(wsel_q);
    end
  end

  // read channel
  wire logic [11:0] ra    = s_axi_araddr;
  wire logic        ra_ok = (ra[11:5] == 7'h00) & (ra[1:0] == 2'b00);
  wire logic        r_take = s_axi_arvalid & s_axi_arready;
  logic [31:0]      rmux;

  always_comb begin
    case (ra[4:2])
      3'd0:    rmux = ctrl_q;
      3'd1:    rmux = geom_q;
      3'd2:    rmux = curgeom_q;
      3'd3:    rmux = curcap_q;
      3'd4:    rmux = {25'h0, tsel_q};
      3'd5:    rmux = tsel_ok ? {24'h0, text_q[tsel_q]} : 32'h0000_0000;
      3'd6:    rmux = {24'h0, wsel_q};
      default: rmux = {16'h0, wdata_q};
    endcase
  end

  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rd_q.data;
  assign s_axi_rresp   = rd_q.resp;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rvalid_q <= 1'b0;
      rd_q     <= '0;
    end else if (r_take) begin
      rvalid_q <= 1'b1;
      rd_q     <= '{data: ra_ok ? rmux : 32'h0, resp: ra_ok ? `IDCW_RESP_OKAY : `IDCW_RESP_SLVERR};
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule : idcw_words

// ===== tb.sv
`timescale 1ns/10ps
`include "idcw_regs.svh"
module tb
  import idcw_pkg::*;
;
  logic          sys_clk, resetn, awready, wready, bvalid, bready, arready, rvalid, rready;
  logic [1:0]    bresp, rresp;
  logic [31:0]   rdata;
  idcw_addr_type aw, ar;
  idcw_wdat_type w;
  int            checked, n_mismatch;
  idcw_words u_dut (.sys_clk(sys_clk), .resetn(resetn), .s_axi_awaddr(aw.addr), .s_axi_awvalid(aw.valid),
    .s_axi_awready(awready), .s_axi_wdata(w.data), .s_axi_wstrb(w.strb), .s_axi_wvalid(w.valid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(ar.addr), .s_axi_arvalid(ar.valid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  idcw_host u_host (.sys_clk(sys_clk), .aw(aw), .awready(awready), .w(w), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .ar(ar), .arready(arready), .r({rdata, rresp}), .rvalid(rvalid),
    .rready(rready));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wreg(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
    logic [1:0] resp;
    u_host.wr(a, d, resp);
    chk("bresp", {30'h0, resp}, {30'h0, er});
  endtask : wreg
  task automatic rreg(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  resp;
    u_host.rd(a, d, resp);
    chk("rdata", d, e);
    chk("rresp", {30'h0, resp}, {30'h0, er});
  endtask : rreg
  task automatic cw(input logic [7:0] n, input logic [15:0] e);
    logic [31:0] d;
    u_host.id_word(n, d);
    chk("word", d, {16'h0, e});
  endtask : cw
  task automatic t_reset;
    rreg(`IDCW_REG_CTRL, 32'h0000_0148, 2'b00);
    cw(8'h31, 16'h0900);
    cw(8'h32, 16'h4000);
    cw(8'h35, 16'h0003);
    cw(8'h0a, 16'h2020);
    cw(8'h17, 16'h2020);
    cw(8'h2e, 16'h2020);
    cw(8'h30, 16'h0000);
    cw(8'h09, 16'h0000);
  endtask : t_reset
  task automatic t_word2;
    logic [15:0] code [4];
    code = '{16'hc837, 16'h8c73, 16'h738c, 16'h37c8};
    for (int i = 0; i < 4; i++) begin
      wreg(`IDCW_REG_CTRL, 32'h0000_0148 | {30'h0, i[0], i[1]});
      cw(8'h02, code[i]);
      cw(8'h00, {13'h0, i[0], 2'b00});
    end
  endtask : t_word2
  task automatic t_caps;
    wreg(`IDCW_REG_CTRL, 32'h00ff_0ffc);
    cw(8'h2f, 16'h00ff);
    cw(8'h31, 16'h2f00);
    cw(8'h32, 16'h4001);
    cw(8'h35, 16'h0007);
    wreg(`IDCW_REG_CTRL, 32'h0001_0400);
    cw(8'h2f, 16'h0001);
    cw(8'h31, 16'h0000);
    cw(8'h32, 16'h4000);
    cw(8'h35, 16'h0000);
    wreg(`IDCW_REG_CTRL, 32'h0000_0a00);
    cw(8'h35, 16'h0002);
    chk("usable", {31'h0, u_host.usable(8'h36, 16'h0000)}, 32'h0);
    chk("usable", {31'h0, u_host.usable(8'd64, 16'h0000)}, 32'h0);
    chk("usable", {31'h0, u_host.usable(8'd64, 16'h0002)}, 32'h1);
  endtask : t_caps
  task automatic t_geom;
    wreg(`IDCW_REG_GEOM, 32'h0011_0010);
    wreg(`IDCW_REG_CURGEOM, 32'h3f10_0400);
    wreg(`IDCW_REG_CURCAP, 32'h0001_e240);
    cw(8'h03, 16'h0010);
    cw(8'h06, 16'h0011);
    cw(8'h36, 16'h0400);
    cw(8'h37, 16'h0010);
    cw(8'h38, 16'h003f);
    cw(8'h39, 16'he240);
    cw(8'h3a, 16'h0001);
  endtask : t_geom
  task automatic t_text;
    wreg(`IDCW_REG_TEXTSEL, 32'h0);
    wreg(`IDCW_REG_TEXTDATA, 32'h53);
    wreg(`IDCW_REG_TEXTDATA, 32'h4e);
    wreg(`IDCW_REG_TEXTDATA, 32'h31);
    cw(8'h0a, 16'h534e);
    cw(8'h0b, 16'h3120);
    cw(8'h13, 16'h2020);
    wreg(`IDCW_REG_TEXTSEL, 32'd27);
    wreg(`IDCW_REG_TEXTDATA, 32'h5a);
    cw(8'h1a, 16'h205a);
    wreg(`IDCW_REG_TEXTSEL, 32'd67);
    wreg(`IDCW_REG_TEXTDATA, 32'h4d);
    wreg(`IDCW_REG_TEXTDATA, 32'h41);
    cw(8'h2e, 16'h204d);
    cw(8'h1b, 16'h2020);
    rreg(`IDCW_REG_TEXTSEL, 32'd68, 2'b00);
    rreg(`IDCW_REG_TEXTDATA, 32'h0, 2'b00);
    wreg(`IDCW_REG_TEXTSEL, 32'h0);
    rreg(`IDCW_REG_TEXTDATA, 32'h53, 2'b00);
  endtask : t_text
  task automatic t_bus;
    rreg(12'h020, 32'h0, 2'b10);
    rreg(12'h002, 32'h0, 2'b10);
    wreg(12'h024, 32'hffff_ffff, 2'b10);
    cw(8'h3b, 16'h0000);
  endtask : t_bus
  task automatic final_report;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    final_report;
  end
  initial begin
    resetn = 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset;
    t_word2;
    t_caps;
    t_geom;
    t_text;
    t_bus;
    final_report;
  end
endmodule : tb
